// file: cpu_instruction_timing_core.sv
// Instruction fetch sequencer and timing decoder of the 8-bit core
// How it works
// - Opcodes decode with classic encoding, addressing modes and status flag effects.
// - Every instruction is timed in plain system clocks, no machine cycles.
// - Most instructions take as many clocks as they have bytes.
// - Conditional branch not taken finishes one clock sooner than taken.
// - No instruction runs longer than eight clocks.
// - 109 instructions with the documented spread of clock costs.
// - One instruction per clock at peak, 25 MIPS at 25MHz.
// - Add, add with carry, subtract with borrow from register: one byte, one clock.
// - Accumulator operations on a direct byte: two bytes, two clocks.
// - Accumulator operations on indirect RAM: one byte, two clocks.
// - Accumulator operations with immediate: two bytes, two clocks.
// - Logic op of immediate into direct byte: three bytes, three clocks.
// - Logic op of accumulator into direct byte: two bytes, two clocks.
// - Indirect increment or decrement takes two clocks; accumulator or register one.
// - Pointer increment is one byte and one clock.
// - Single-operand accumulator operations are one byte and one clock.
// - External data move reaches flash for reads and writes when enabled.
// - Flash reachable bytewise through code byte move and external data move.
// - External data move reaches data-space RAM when flash is not selected.
// - External data moves, both address widths, are one byte and three clocks.
// - Carry jumps are two bytes, two clocks not taken, three taken.
`timescale 1ns/10ps
`default_nettype none

module cpu_instruction_timing_core (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic [7:0]  code_data_i,
	input  wire logic        branch_taken_i,
	input  wire logic [15:0] branch_target_i,
	input  wire logic [1:0]  program_store_control_i,
	output logic [15:0]      code_addr_o,
	output logic             instr_start_o,
	output logic             retire_o,
	output logic [7:0]       retire_opcode_o,
	output logic [7:0]       retire_operand1_o,
	output logic [7:0]       retire_operand2_o,
	output logic [1:0]       retire_len_o,
	output logic [3:0]       retire_cycles_o,
	output logic             retire_taken_o,
	output logic [2:0]       retire_addr_mode_o,
	output logic [2:0]       retire_flags_o,
	output logic             retire_reserved_o,
	output logic             xdata_req_o,
	output logic             xdata_write_o,
	output logic             xdata_wide_o,
	output logic             xdata_to_flash_o,
	output logic             code_move_req_o
);

	// Builds one timing entry
	function automatic cpu_timing_pkg::timing_s mk(
		input logic [1:0]                len,
		input logic [3:0]                cyc,
		input cpu_timing_pkg::op_class_e cls
	);
		cpu_timing_pkg::timing_s t;
		t.len = len;
		t.cyc = cyc;
		t.cls = cls;
		return t;
	endfunction

	// Length, base clock count and class per opcode; taken branches add one
	function automatic cpu_timing_pkg::timing_s decode_timing(input logic [7:0] op);
		logic [3:0]              hi;
		logic [3:0]              lo;
		cpu_timing_pkg::timing_s t;
		hi = op[7:4];
		lo = op[3:0];
		t  = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_1, cpu_timing_pkg::CLS_PLAIN);
		if (lo[3]) begin
			// Register operand column
			case (hi)
				4'h7, 4'h8, 4'hA: t = mk(cpu_timing_pkg::LEN_2, cpu_timing_pkg::CYC_2, cpu_timing_pkg::CLS_PLAIN);
				4'hB: t = mk(cpu_timing_pkg::LEN_3, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_COND);
				4'hD: t = mk(cpu_timing_pkg::LEN_2, cpu_timing_pkg::CYC_2, cpu_timing_pkg::CLS_COND);
				default: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_1, cpu_timing_pkg::CLS_PLAIN);
			endcase
		end else begin
			case (lo)
				4'h6, 4'h7: begin
					// Indirect RAM column
					case (hi)
						4'h7, 4'h8, 4'hA: t = mk(cpu_timing_pkg::LEN_2, cpu_timing_pkg::CYC_2, cpu_timing_pkg::CLS_PLAIN);
						4'hB: t = mk(cpu_timing_pkg::LEN_3, cpu_timing_pkg::CYC_4, cpu_timing_pkg::CLS_COND);
						default: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_2, cpu_timing_pkg::CLS_PLAIN);
					endcase
				end
				4'h5: begin
					// Direct byte column
					case (hi)
						4'h7, 4'h8: t = mk(cpu_timing_pkg::LEN_3, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_PLAIN);
						4'hA: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_1, cpu_timing_pkg::CLS_RSVD);
						4'hB, 4'hD: t = mk(cpu_timing_pkg::LEN_3, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_COND);
						default: t = mk(cpu_timing_pkg::LEN_2, cpu_timing_pkg::CYC_2, cpu_timing_pkg::CLS_PLAIN);
					endcase
				end
				4'h4: begin
					// Accumulator and immediate column
					case (hi)
						4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_1, cpu_timing_pkg::CLS_PLAIN);
						4'h8: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_8, cpu_timing_pkg::CLS_PLAIN);
						4'hA: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_4, cpu_timing_pkg::CLS_PLAIN);
						4'hB: t = mk(cpu_timing_pkg::LEN_3, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_COND);
						default: t = mk(cpu_timing_pkg::LEN_2, cpu_timing_pkg::CYC_2, cpu_timing_pkg::CLS_PLAIN);
					endcase
				end
				4'h3: begin
					case (hi)
						4'h4, 4'h5, 4'h6: t = mk(cpu_timing_pkg::LEN_3, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_PLAIN);
						4'h7: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_JUMP);
						4'h8, 4'h9: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_CODE);
						4'hE: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_XREAD);
						4'hF: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_XWRITE);
						default: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_1, cpu_timing_pkg::CLS_PLAIN);
					endcase
				end
				4'h2: begin
					case (hi)
						4'h0, 4'h1: t = mk(cpu_timing_pkg::LEN_3, cpu_timing_pkg::CYC_4, cpu_timing_pkg::CLS_JUMP);
						4'h2, 4'h3: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_5, cpu_timing_pkg::CLS_JUMP);
						4'hE: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_XREAD);
						4'hF: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_XWRITE);
						default: t = mk(cpu_timing_pkg::LEN_2, cpu_timing_pkg::CYC_2, cpu_timing_pkg::CLS_PLAIN);
					endcase
				end
				4'h1: t = mk(cpu_timing_pkg::LEN_2, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_JUMP);
				default: begin
					// Branch and bit column
					case (hi)
						4'h0: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_1, cpu_timing_pkg::CLS_PLAIN);
						4'h1, 4'h2, 4'h3: t = mk(cpu_timing_pkg::LEN_3, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_COND);
						4'h4, 4'h5, 4'h6, 4'h7: t = mk(cpu_timing_pkg::LEN_2, cpu_timing_pkg::CYC_2, cpu_timing_pkg::CLS_COND);
						4'h8: t = mk(cpu_timing_pkg::LEN_2, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_JUMP);
						4'h9: t = mk(cpu_timing_pkg::LEN_3, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_PLAIN);
						4'hE: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_XREAD);
						4'hF: t = mk(cpu_timing_pkg::LEN_1, cpu_timing_pkg::CYC_3, cpu_timing_pkg::CLS_XWRITE);
						default: t = mk(cpu_timing_pkg::LEN_2, cpu_timing_pkg::CYC_2, cpu_timing_pkg::CLS_PLAIN);
					endcase
				end
			endcase
		end
		return t;
	endfunction

	// Addressing mode of the operand, by opcode column
	function automatic cpu_timing_pkg::addr_mode_e decode_mode(input logic [7:0] op);
		logic [3:0]                 hi;
		cpu_timing_pkg::addr_mode_e m;
		hi = op[7:4];
		m  = cpu_timing_pkg::AM_IMPLIED;
		case (op[3:0])
			4'h0: begin
				case (hi)
					4'h0: m = cpu_timing_pkg::AM_IMPLIED;
					4'h1, 4'h2, 4'h3, 4'hA, 4'hB: m = cpu_timing_pkg::AM_BIT;
					4'h9: m = cpu_timing_pkg::AM_IMMEDIATE;
					4'hC, 4'hD: m = cpu_timing_pkg::AM_DIRECT;
					4'hE, 4'hF: m = cpu_timing_pkg::AM_INDIRECT;
					default: m = cpu_timing_pkg::AM_RELATIVE;
				endcase
			end
			4'h1: m = cpu_timing_pkg::AM_ABSOLUTE;
			4'h2: begin
				case (hi)
					4'h0, 4'h1: m = cpu_timing_pkg::AM_ABSOLUTE;
					4'h2, 4'h3: m = cpu_timing_pkg::AM_IMPLIED;
					4'h4, 4'h5, 4'h6: m = cpu_timing_pkg::AM_DIRECT;
					4'hE, 4'hF: m = cpu_timing_pkg::AM_INDIRECT;
					default: m = cpu_timing_pkg::AM_BIT;
				endcase
			end
			4'h3: begin
				case (hi)
					4'h4, 4'h5, 4'h6: m = cpu_timing_pkg::AM_DIRECT;
					4'h7, 4'h8, 4'h9, 4'hE, 4'hF: m = cpu_timing_pkg::AM_INDIRECT;
					default: m = cpu_timing_pkg::AM_IMPLIED;
				endcase
			end
			4'h4: begin
				case (hi)
					4'h0, 4'h1, 4'h8, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF: m = cpu_timing_pkg::AM_IMPLIED;
					default: m = cpu_timing_pkg::AM_IMMEDIATE;
				endcase
			end
			4'h5: m = cpu_timing_pkg::AM_DIRECT;
			4'h6, 4'h7: m = cpu_timing_pkg::AM_INDIRECT;
			default: m = cpu_timing_pkg::AM_REGISTER;
		endcase
		return m;
	endfunction

	// Status word flags that an opcode may change, as {CY, AC, OV}
	function automatic logic [2:0] decode_flags(input logic [7:0] op);
		logic [2:0] f;
		f = cpu_timing_pkg::FLAGS_NONE;
		if ((op[7:4] == 4'h2 || op[7:4] == 4'h3 || op[7:4] == 4'h9) && op[3:0] >= 4'h4) begin
			f = cpu_timing_pkg::FLAGS_ARITH;
		end else if (op == 8'h84 || op == 8'hA4) begin
			f = cpu_timing_pkg::FLAGS_CY_OV;
		end else if (op[7:4] == 4'hB && op[3:0] >= 4'h4 && op != cpu_timing_pkg::OP_RESERVED) begin
			f = cpu_timing_pkg::FLAGS_CY;
		end else begin
			case (op)
				8'h13, 8'h33, 8'hD4, 8'h72, 8'h82, 8'hA0, 8'hB0, 8'hA2, 8'hB3, 8'hC3, 8'hD3: f = cpu_timing_pkg::FLAGS_CY;
				default: f = cpu_timing_pkg::FLAGS_NONE;
			endcase
		end
		return f;
	endfunction

	cpu_timing_pkg::seq_state_e state;
	cpu_timing_pkg::seq_state_e next_state;
	logic [15:0]                pc;
	logic [15:0]                fetch_addr;
	logic [7:0]                 opcode;
	logic [7:0]                 operand1;
	logic [7:0]                 operand2;
	logic [3:0]                 cycle_no;

	// Decode runs on the opcode pin in its first clock, on the latched copy after
	wire logic                       in_decode  = (state == cpu_timing_pkg::ST_DECODE);
	wire logic                       in_taken   = (state == cpu_timing_pkg::ST_TAKEN);
	wire logic [7:0]                 op_now     = in_decode ? code_data_i : opcode;
	wire cpu_timing_pkg::timing_s    tim        = decode_timing(op_now);
	wire logic [3:0]                 idx        = in_decode ? cpu_timing_pkg::CYC_1 : cycle_no;
	wire logic [3:0]                 len_w      = {2'h0, tim.len};
	wire logic                       is_cond    = (tim.cls == cpu_timing_pkg::CLS_COND);
	wire logic                       last_base  = (idx == tim.cyc);
	wire logic                       extend     = last_base && is_cond && branch_taken_i && !in_taken;
	wire logic                       done       = in_taken || (last_base && !extend);
	wire logic                       redirect   = in_taken || (tim.cls == cpu_timing_pkg::CLS_JUMP);
	wire logic [15:0]                seq_pc     = pc + {14'h0, tim.len};
	wire logic [15:0]                next_pc    = redirect ? branch_target_i : seq_pc;
	wire logic                       more_bytes = (idx < len_w);
	wire logic [15:0]                next_fetch = done ? next_pc
	                                            : (more_bytes ? fetch_addr + cpu_timing_pkg::ADDR_STEP : fetch_addr);
	wire logic [3:0]                 next_cycle = done ? cpu_timing_pkg::CYC_1 : idx + cpu_timing_pkg::CYC_1;
	wire logic                       is_xmove   = (tim.cls == cpu_timing_pkg::CLS_XREAD)
	                                           || (tim.cls == cpu_timing_pkg::CLS_XWRITE);
	wire logic                       is_xwrite  = (tim.cls == cpu_timing_pkg::CLS_XWRITE);
	// Writes and reads are steered to flash by separate store-control bits
	wire logic                       to_flash   = is_xwrite ? program_store_control_i[cpu_timing_pkg::PSC_FLASH_WRITE_BIT]
	                                                        : program_store_control_i[cpu_timing_pkg::PSC_FLASH_READ_BIT];
	// Taken branches cost one clock above the base figure
	wire logic [3:0]                 used_cyc   = in_taken ? tim.cyc + cpu_timing_pkg::CYC_1 : tim.cyc;

	// Sequencer state selection
	always_comb begin
		next_state = cpu_timing_pkg::ST_EXEC;
		if (done) begin
			next_state = cpu_timing_pkg::ST_DECODE;
		end else if (extend) begin
			next_state = cpu_timing_pkg::ST_TAKEN;
		end
	end

	assign code_addr_o   = fetch_addr;
	assign instr_start_o = in_decode;

	// Program counter, fetch pointer and clock counter
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state      <= cpu_timing_pkg::ST_DECODE;
			pc         <= cpu_timing_pkg::RESET_PC;
			fetch_addr <= cpu_timing_pkg::RESET_PC;
			cycle_no   <= cpu_timing_pkg::CYC_1;
		end else begin
			state      <= next_state;
			fetch_addr <= next_fetch;
			cycle_no   <= next_cycle;
			if (done) begin
				pc <= next_pc;
			end
		end
	end

	// Opcode and operand capture; one byte per clock keeps clocks at least equal to bytes
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			opcode   <= cpu_timing_pkg::OP_RESET;
			operand1 <= cpu_timing_pkg::OP_RESET;
			operand2 <= cpu_timing_pkg::OP_RESET;
		end else begin
			if (in_decode) begin
				opcode <= code_data_i;
			end
			if (!in_decode && idx == cpu_timing_pkg::CYC_2 && len_w >= cpu_timing_pkg::CYC_2) begin
				operand1 <= code_data_i;
			end
			if (idx == cpu_timing_pkg::CYC_3 && len_w == cpu_timing_pkg::CYC_3) begin
				operand2 <= code_data_i;
			end
		end
	end

	// Memory move requests, raised in the second clock of the instruction
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			xdata_req_o      <= 1'b0;
			xdata_write_o    <= 1'b0;
			xdata_wide_o     <= 1'b0;
			xdata_to_flash_o <= 1'b0;
			code_move_req_o  <= 1'b0;
		end else begin
			xdata_req_o     <= in_decode && is_xmove;
			code_move_req_o <= in_decode && (tim.cls == cpu_timing_pkg::CLS_CODE);
			if (in_decode && is_xmove) begin
				xdata_write_o    <= is_xwrite;
				xdata_wide_o     <= ~op_now[1]; // Pointer form has bit 1 clear
				xdata_to_flash_o <= to_flash;
			end
		end
	end

	// Retirement record, valid for one clock after the last clock
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			retire_o           <= 1'b0;
			retire_opcode_o    <= cpu_timing_pkg::OP_RESET;
			retire_operand1_o  <= cpu_timing_pkg::OP_RESET;
			retire_operand2_o  <= cpu_timing_pkg::OP_RESET;
			retire_len_o       <= cpu_timing_pkg::LEN_1;
			retire_cycles_o    <= cpu_timing_pkg::CYC_1;
			retire_taken_o     <= 1'b0;
			retire_addr_mode_o <= cpu_timing_pkg::AM_IMPLIED;
			retire_flags_o     <= cpu_timing_pkg::FLAGS_NONE;
			retire_reserved_o  <= 1'b0;
		end else begin
			retire_o <= done;
			if (done) begin
				retire_opcode_o    <= op_now;
				retire_operand1_o  <= (len_w >= cpu_timing_pkg::CYC_2 && idx == cpu_timing_pkg::CYC_2) ? code_data_i : operand1;
				retire_operand2_o  <= (len_w == cpu_timing_pkg::CYC_3 && idx == cpu_timing_pkg::CYC_3) ? code_data_i : operand2;
				retire_len_o       <= tim.len;
				retire_cycles_o    <= used_cyc;
				retire_taken_o     <= in_taken || (tim.cls == cpu_timing_pkg::CLS_JUMP);
				retire_addr_mode_o <= decode_mode(op_now);
				retire_flags_o     <= decode_flags(op_now);
				retire_reserved_o  <= (tim.cls == cpu_timing_pkg::CLS_RSVD);
			end
		end
	end

endmodule

`default_nettype wire

// file: cpu_timing_pkg.sv
// Shared constants, types and encodings for the instruction timing core
package cpu_timing_pkg;

	// Instruction lengths in program bytes
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;

	// Execution costs in system clocks
	localparam logic [3:0] CYC_1   = 4'h1;
	localparam logic [3:0] CYC_2   = 4'h2;
	localparam logic [3:0] CYC_3   = 4'h3;
	localparam logic [3:0] CYC_4   = 4'h4;
	localparam logic [3:0] CYC_5   = 4'h5;
	localparam logic [3:0] CYC_8   = 4'h8;
	localparam logic [3:0] CYC_MAX = 4'h8;

	// Clocking figures
	localparam int CLK_MHZ       = 100;
	localparam int PEAK_CLK_MHZ  = 25;
	localparam int PEAK_MIPS     = 25;

	// Program counter and fetch address
	localparam logic [15:0] RESET_PC  = 16'h0000;
	localparam logic [15:0] ADDR_STEP = 16'h0001;

	// Reserved opcode of the instruction set
	localparam logic [7:0] OP_RESERVED = 8'hA5;
	localparam logic [7:0] OP_RESET    = 8'h00;

	// Program store control bit positions
	localparam int PSC_FLASH_WRITE_BIT = 0;
	localparam int PSC_FLASH_READ_BIT  = 1;

	// Status word flag mask bit positions
	localparam int FLAG_CY = 2;
	localparam int FLAG_AC = 1;
	localparam int FLAG_OV = 0;
	localparam logic [2:0] FLAGS_NONE  = 3'h0;
	localparam logic [2:0] FLAGS_ARITH = 3'h7;
	localparam logic [2:0] FLAGS_CY    = 3'h4;
	localparam logic [2:0] FLAGS_CY_OV = 3'h5;

	typedef enum logic [2:0] {
		CLS_PLAIN  = 3'h0,
		CLS_COND   = 3'h1,
		CLS_JUMP   = 3'h2,
		CLS_XREAD  = 3'h3,
		CLS_XWRITE = 3'h4,
		CLS_CODE   = 3'h5,
		CLS_RSVD   = 3'h6
	} op_class_e;

	typedef enum logic [2:0] {
		AM_IMPLIED   = 3'h0,
		AM_REGISTER  = 3'h1,
		AM_DIRECT    = 3'h2,
		AM_INDIRECT  = 3'h3,
		AM_IMMEDIATE = 3'h4,
		AM_BIT       = 3'h5,
		AM_RELATIVE  = 3'h6,
		AM_ABSOLUTE  = 3'h7
	} addr_mode_e;

	typedef enum logic [2:0] {
		ST_DECODE = 3'b001,
		ST_EXEC   = 3'b010,
		ST_TAKEN  = 3'b100
	} seq_state_e;

	typedef struct packed {
		logic [1:0] len;
		logic [3:0] cyc;
		op_class_e  cls;
	} timing_s;

endpackage

// file: cpu_timing_props.sv
// Port checks for the instruction timing core
`timescale 1ns/10ps
`default_nettype none
module cpu_timing_props (
	input wire logic        clk_i,
	input wire logic        srst_i,
	input wire logic [7:0]  code_data_i,
	input wire logic        branch_taken_i,
	input wire logic [15:0] branch_target_i,
	input wire logic [1:0]  program_store_control_i,
	input wire logic [15:0] code_addr_o,
	input wire logic        instr_start_o,
	input wire logic        retire_o,
	input wire logic [3:0]  retire_cycles_o,
	input wire logic        retire_taken_o,
	input wire logic        xdata_req_o,
	input wire logic        xdata_write_o,
	input wire logic        xdata_wide_o,
	input wire logic        xdata_to_flash_o,
	input wire logic        code_move_req_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	logic [3:0] cnt;

	// Opcode classes of interest
	wire logic op_x = code_data_i inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};
	wire logic op_c = code_data_i inside {8'h40, 8'h50};
	wire logic op_1 = code_data_i inside {8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hD4, 8'hA3};

	// Clocks spent so far; independent of the core's own count
	always_ff @(posedge clk_i) begin
		if (srst_i || instr_start_o) begin
			cnt <= 4'h1;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end

	AST_CYCLES_COUNTED: assert property (retire_o |-> retire_cycles_o == cnt)
		else $error("retired cycle count differs from clocks spent");
	AST_RETIRE_AT_START: assert property (retire_o |-> instr_start_o)
		else $error("retire pulse outside an opcode clock");
	AST_NEVER_OVER_EIGHT: assert property (!instr_start_o |-> cnt < 4'h8)
		else $error("instruction ran past eight clocks");
	AST_DIVIDE_EIGHT: assert property (instr_start_o && code_data_i == 8'h84 |=>
		!instr_start_o [*7] ##1 (retire_o && retire_cycles_o == 4'h8))
		else $error("divide did not take eight clocks");
	AST_ONE_CLOCK_OPS: assert property (instr_start_o && op_1 |=> retire_o)
		else $error("single clock operation took longer");
	AST_XMOVE_THREE: assert property (instr_start_o && op_x |=> xdata_req_o ##1
		(!xdata_req_o && !instr_start_o) ##1 (retire_o && retire_cycles_o == 4'h3))
		else $error("external move timing wrong");
	AST_XMOVE_TARGET: assert property (instr_start_o && op_x |=>
		xdata_write_o == $past(code_data_i[4]) && xdata_wide_o == ($past(code_data_i[1:0]) == 2'h0)
		&& xdata_to_flash_o == (xdata_write_o ? $past(program_store_control_i[0])
		: $past(program_store_control_i[1])))
		else $error("external move direction or space wrong");
	AST_XREQ_CAUSE: assert property (xdata_req_o |->
		$past(instr_start_o) && $past(code_data_i[7:5]) == 3'h7)
		else $error("external request without a move opcode");
	AST_CODE_MOVE: assert property (instr_start_o && code_data_i inside {8'h83, 8'h93} |=>
		code_move_req_o ##1 !code_move_req_o)
		else $error("code byte move request missing");
	AST_COND_NOT_TAKEN: assert property (instr_start_o && op_c ##1 !branch_taken_i |=>
		retire_o && retire_cycles_o == 4'h2 && !retire_taken_o)
		else $error("untaken branch not two clocks");
	AST_COND_TAKEN: assert property (instr_start_o && op_c ##1 branch_taken_i |=>
		!instr_start_o ##1 (retire_o && retire_cycles_o == 4'h3 && retire_taken_o
		&& code_addr_o == $past(branch_target_i)))
		else $error("taken branch not three clocks");

	// Main scenarios reached
	COV_XMOVE: cover property (xdata_req_o);
	COV_CODE_MOVE: cover property (code_move_req_o);
	COV_TAKEN: cover property (retire_o && retire_taken_o);
	COV_DIVIDE: cover property (instr_start_o && code_data_i == 8'h84);
endmodule

bind cpu_instruction_timing_core cpu_timing_props u_props (
	.clk_i                   (clk_i),
	.srst_i                  (srst_i),
	.code_data_i             (code_data_i),
	.branch_taken_i          (branch_taken_i),
	.branch_target_i         (branch_target_i),
	.program_store_control_i (program_store_control_i),
	.code_addr_o             (code_addr_o),
	.instr_start_o           (instr_start_o),
	.retire_o                (retire_o),
	.retire_cycles_o         (retire_cycles_o),
	.retire_taken_o          (retire_taken_o),
	.xdata_req_o             (xdata_req_o),
	.xdata_write_o           (xdata_write_o),
	.xdata_wide_o            (xdata_wide_o),
	.xdata_to_flash_o        (xdata_to_flash_o),
	.code_move_req_o         (code_move_req_o)
);
`default_nettype wire

// file: prog_mem.sv
// Program flash model answering fetches in the same clock
`timescale 1ns/10ps
`default_nettype none
module prog_mem (
	input  wire logic [15:0] addr_i,
	output logic [7:0]       data_o
);
	logic [7:0] mem [1024];

	// Bytewise image; past its end the store reads as no-operation filler
	assign data_o = (addr_i < 16'h0400) ? mem[addr_i[9:0]] : 8'h00;
endmodule
`default_nettype wire

// file: tb.sv
// Bench: instruction streams checked against a byte and clock cost model
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk_i;
	logic        srst_i;
	logic [7:0]  code_data_i;
	logic        branch_taken_i;
	logic [15:0] branch_target_i;
	logic [1:0]  program_store_control_i;
	logic [15:0] code_addr_o;
	logic        instr_start_o;
	logic        retire_o;
	logic [7:0]  retire_opcode_o;
	logic [7:0]  retire_operand1_o;
	logic [7:0]  retire_operand2_o;
	logic [1:0]  retire_len_o;
	logic [2:0]  retire_addr_mode_o;
	logic [3:0]  retire_cycles_o;
	logic        retire_taken_o;
	logic [2:0]  retire_flags_o;
	logic        retire_reserved_o;
	int          n_errors;
	int          checks_done;
	int          k;
	logic        tk [1024];
	logic [15:0] pcs [1025];
	logic [37:0] exp_q [$];
	logic [37:0] e;
	// Rows: opcode, bytes, clocks, flag mask; branch rows hold the untaken cost
	logic [19:0] tbl [39] = '{20'h28117, 20'h38117, 20'h98117, 20'h25227, 20'h95227,
		20'h26127, 20'h36127, 20'h24227, 20'h54220, 20'h53330, 20'h43330, 20'h63330,
		20'h52220, 20'h42220, 20'h62220, 20'h06120, 20'h16120, 20'h04110, 20'h18110,
		20'hA3110, 20'hE4110, 20'hF4110, 20'h23110, 20'h33114, 20'h03110, 20'h13114,
		20'hD4114, 20'hE0130, 20'hE2130, 20'hE3130, 20'hF0130, 20'hF2130, 20'hF3130,
		20'h93130, 20'h84185, 20'hA4145, 20'h40220, 20'h50220, 20'hA5110};
	// Operand addressing mode of each row, in the package's mode codes
	int          am [39] = '{1, 1, 1, 2, 2, 3, 3, 4, 4, 2, 2, 2, 2, 2, 2, 3, 3, 0, 1, 0, 0, 0, 0,
		0, 0, 0, 0, 3, 3, 3, 3, 3, 3, 3, 0, 0, 6, 6, 2};

	cpu_instruction_timing_core uut (
		.clk_i                   (clk_i),
		.srst_i                  (srst_i),
		.code_data_i             (code_data_i),
		.branch_taken_i          (branch_taken_i),
		.branch_target_i         (branch_target_i),
		.program_store_control_i (program_store_control_i),
		.code_addr_o             (code_addr_o),
		.instr_start_o           (instr_start_o),
		.retire_o                (retire_o),
		.retire_opcode_o         (retire_opcode_o),
		.retire_operand1_o       (retire_operand1_o),
		.retire_operand2_o       (retire_operand2_o),
		.retire_len_o            (retire_len_o),
		.retire_cycles_o         (retire_cycles_o),
		.retire_taken_o          (retire_taken_o),
		.retire_addr_mode_o      (retire_addr_mode_o),
		.retire_flags_o          (retire_flags_o),
		.retire_reserved_o       (retire_reserved_o),
		.xdata_req_o             (),
		.xdata_write_o           (),
		.xdata_wide_o            (),
		.xdata_to_flash_o        (),
		.code_move_req_o         ()
	);

	prog_mem pm (
		.addr_i (code_addr_o),
		.data_o (code_data_i)
	);

	// Free-running 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			n_errors++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, want);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Branch outcome and target follow each opcode clock; retirements meet the model
	always @(posedge clk_i) begin
		program_store_control_i <= 2'($urandom);
		if (srst_i) begin
			branch_taken_i <= 1'b0;
			branch_target_i <= 16'h0000;
		end else if (instr_start_o) begin
			branch_taken_i <= tk[k];
			branch_target_i <= pcs[k + 1];
			k = k + 1;
		end
		if (!srst_i && retire_o && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			check({retire_opcode_o, retire_operand1_o, retire_operand2_o, retire_flags_o,
				retire_reserved_o}, 32'(e[34:7]));
			check({retire_len_o, retire_cycles_o, retire_taken_o}, 32'(e[6:0]));
			check(32'(retire_addr_mode_o), 32'(e[37:35]));
		end
	end

	// Reset, load a stream into the store, model its retirements, run it out
	task automatic run(input int n, input logic dir);
		logic [19:0] r;
		logic [15:0] pc;
		logic [7:0]  o1;
		logic [7:0]  o2;
		logic [7:0]  m1;
		logic [7:0]  m2;
		logic        te;
		int          j;
		pc = 16'h0000;
		m1 = 8'h00;
		m2 = 8'h00;
		srst_i <= 1'b1;
		@(posedge clk_i);
		exp_q.delete();
		foreach (pm.mem[a]) pm.mem[a] = 8'h00;
		for (int i = 0; i < n; i++) begin
			j = dir ? i % 39 : $urandom % 39;
			r = tbl[j];
			o1 = 8'($urandom);
			o2 = 8'($urandom);
			te = (dir ? (i >= 39) : 1'($urandom)) && r[19:12] inside {8'h40, 8'h50};
			tk[i] = te;
			pcs[i] = pc;
			pm.mem[pc] = r[19:12];
			if (r[11:8] > 4'h1) begin
				pm.mem[pc + 16'h0001] = o1;
				m1 = o1;
			end
			if (r[11:8] > 4'h2) begin
				pm.mem[pc + 16'h0002] = o2;
				m2 = o2;
			end
			exp_q.push_back({3'(am[j]), r[19:12], m1, m2, r[2:0], r[19:12] == 8'hA5, r[9:8],
				r[7:4] + {3'h0, te}, te});
			pc = pc + 16'(r[11:8]);
		end
		pcs[n] = pc;
		k = 0;
		@(posedge clk_i);
		srst_i <= 1'b0;
		for (int w = 0; w < 4000 && exp_q.size() > 0; w++) @(posedge clk_i);
		if (exp_q.size() > 0) begin
			n_errors++;
			end_of_test();
		end
		$display("test of %0d instructions done, mismatches %0d", n, n_errors);
	endtask

	// Table sweep with both branch outcomes, then a random stream after a fresh reset
	initial begin
		n_errors = 0;
		checks_done = 0;
		k = 0;
		void'($urandom(32'h8279));
		run(78, 1'b1);
		run(300, 1'b0);
		end_of_test();
	end
endmodule
`default_nettype wire
